/* rtl/rpss_defines.vh */
// Purpose: constants for the render pixel source select block
// Assumes: one drawing clock, synchronous active-high reset
// Notes:   command codes are local encodings of the command fetcher
`ifndef RPSS_DEFINES_VH
`define RPSS_DEFINES_VH

// command type codes (4 bits)
`define RPSS_CMD_QUAD_FILL_MULTIVALUE_SRC 4'h0
`define RPSS_CMD_QUAD_FILL_BINARY_SRC     4'h1
`define RPSS_CMD_QUAD_FILL_PARAM_COLOR    4'h2
`define RPSS_CMD_SOLID_LINE_ABS           4'h3
`define RPSS_CMD_SOLID_LINE_REL           4'h4
`define RPSS_CMD_PATTERN_LINE_ABS         4'h5
`define RPSS_CMD_PATTERN_LINE_REL         4'h6
`define RPSS_CMD_WORK_LINE_ABS            4'h7
`define RPSS_CMD_WORK_LINE_REL            4'h8
`define RPSS_CMD_WORK_TRAPEZOID_ABS       4'h9
`define RPSS_CMD_WORK_TRAPEZOID_REL       4'ha
`define RPSS_CMD_WORK_RECT_CLEAR          4'hb
`define RPSS_CMD_OTHER                    4'hf

// attribute field bit positions
`define RPSS_ATTR_TRANSPARENCY_SEL 9
`define RPSS_ATTR_SOURCE_REPEAT    8
`define RPSS_ATTR_USER_ENABLE_A    7
`define RPSS_ATTR_RELATIVE_ADDR    6
`define RPSS_ATTR_NET              5
`define RPSS_ATTR_EVEN_ODD_SELECT  4
`define RPSS_ATTR_POS3             3
`define RPSS_ATTR_POS2             2
`define RPSS_ATTR_POS1             1
`define RPSS_ATTR_POS0             0
`define RPSS_ATTR_W                10

// source classes
`define RPSS_SRC_NONE   2'h0
`define RPSS_SRC_IMAGE  2'h1
`define RPSS_SRC_PARAM  2'h2

// fifo shape and reset values
`define RPSS_FIFO_DEPTH 32
`define RPSS_FIFO_AW    5
`define RPSS_PIX_W      16
`define RPSS_ZERO_PIX   16'h0000

`endif

/* rtl/rpss_fifo.v */
// Purpose: synchronous valid/ready FIFO for pixel words
// Assumes: single clock, synchronous active-high reset
// Notes:   flip-flop storage; full and empty are exact
`timescale 1ns/100ps
`default_nettype none
module rpss_fifo
#(
  parameter WIDTH = 17,
  parameter DEPTH = 32,
  parameter AW    = 5
)
(
  // clock and reset
  input  wire             i_sys_clk,
  input  wire             i_sys_rst,
  // write side
  input  wire             i_wr_valid,
  input  wire [WIDTH-1:0] i_wr_data,
  output wire             o_wr_ready,
  // read side
  output wire             o_rd_valid,
  output wire [WIDTH-1:0] o_rd_data,
  input  wire             i_rd_ready
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  // handshake terms
  assign o_wr_ready = (count_q != DEPTH[AW:0]);
  assign o_rd_valid = (count_q != {(AW+1){1'b0}});
  assign o_rd_data  = mem_q[rd_ptr_q];
  assign push       = i_wr_valid & o_wr_ready;
  assign pop        = o_rd_valid & i_rd_ready;

  // storage write
  always @(posedge i_sys_clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= i_wr_data;
  end

  // pointers and occupancy
  always @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      if (push & ~pop)
        count_q <= count_q + 1'b1;
      else if (pop & ~push)
        count_q <= count_q - 1'b1;
    end
  end

endmodule
`default_nettype wire

/* rtl/rpss_top.v */
// Operation
// - source image fetched only by multivalue/binary quad fills and pattern lines
// - param colour used by colour quad fill, solid lines and work lines
// - only the three quad fills may read the work mask
// - work data written only by work trapezoids, work lines, rect clear
// - work mask is read in the same pass as the source or colour
// - multivalue pixels are 8 or 16 bit; low byte holds smaller x
// - binary source is a linear bit array, leftmost pixel in lsb
// - binary 0 gives background, 1 foreground; transparent skips zeros
// - all-zero multivalue pixel is transparent and not written
// - at 16 bpp the colour parameter is the rgb value directly
// - work lines take the written bit from even/odd select
// - even/odd select 0 writes 0, 1 writes 1 into work memory
// - colour quad fill with mask paints work shape in parameter colour
// - with mask enabled a pixel is drawn only where the work bit is 1
// - attributes decoded per command from its mode field; transparency, work mask read and work value depend on command type
// - transparency chosen per command; opaque maps 0/1 to back/foreground
//
// Purpose: per-command pixel source selection and colour expansion
// Assumes: command fetcher presents one command word, then a stream of 16-bit
//          source words; inputs synchronous to i_sys_clk
// Notes:   output pixels pass through a 32-word FIFO; o_src_ready stalls source
`timescale 1ns/100ps
`default_nettype none
`include "rpss_defines.vh"
module rpss_top
(
  // clock and reset
  input  wire        i_sys_clk,
  input  wire        i_sys_rst,
  // command load
  input  wire        i_cmd_valid,
  input  wire [3:0]  i_cmd_type,
  input  wire [15:0] i_cmd_mode,
  input  wire [15:0] i_background_color,
  input  wire [15:0] i_foreground_color,
  input  wire        i_pix16_mode,
  // source data stream (image words or parameter-colour pixel slots)
  input  wire        i_src_valid,
  input  wire [15:0] i_src_word,
  input  wire        i_src_work_bit,
  input  wire        i_src_last,
  output reg         o_src_ready,
  // decoded command class
  output reg  [1:0]  o_src_class,
  output reg         o_fetch_source,
  output reg         o_read_work,
  output reg         o_write_work,
  output reg         o_work_value,
  output reg         o_busy,
  // decoded attributes
  output reg         o_transparency_sel,
  output reg         o_source_repeat_style,
  output reg         o_user_enable_a,
  output reg         o_relative_source_addr,
  output reg         o_net_draw,
  output reg         o_even_odd_select,
  output reg  [3:0]  o_cmd_dep_bits,
  // pixel output
  output reg         o_pix_valid,
  output reg  [15:0] o_pix_color,
  output reg         o_pix_write,
  input  wire        i_pix_ready
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  localparam ST_IDLE  = 2'h0;
  localparam ST_RUN   = 2'h1;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [3:0]  cmd_q;
  reg  [9:0]  attr_q;
  reg  [15:0] bg_q;
  reg  [15:0] fg_q;
  reg         pix16_q;
  reg  [15:0] word_q;
  reg         word_work_q;
  reg         word_last_q;
  reg  [3:0]  bit_idx_q;
  reg         have_word_q;

  //////////////////////////////////////////////////////////////////////////////
  // command class decode
  wire is_mv      = (i_cmd_type == `RPSS_CMD_QUAD_FILL_MULTIVALUE_SRC);
  wire is_bin     = (i_cmd_type == `RPSS_CMD_QUAD_FILL_BINARY_SRC);
  wire is_pc      = (i_cmd_type == `RPSS_CMD_QUAD_FILL_PARAM_COLOR);
  wire is_pattern_line_abs   = (i_cmd_type == `RPSS_CMD_PATTERN_LINE_ABS) |
                    (i_cmd_type == `RPSS_CMD_PATTERN_LINE_REL);
  wire is_sline   = (i_cmd_type == `RPSS_CMD_SOLID_LINE_ABS) |
                    (i_cmd_type == `RPSS_CMD_SOLID_LINE_REL);
  wire is_wline   = (i_cmd_type == `RPSS_CMD_WORK_LINE_ABS) |
                    (i_cmd_type == `RPSS_CMD_WORK_LINE_REL);
  wire is_wtrap   = (i_cmd_type == `RPSS_CMD_WORK_TRAPEZOID_ABS) |
                    (i_cmd_type == `RPSS_CMD_WORK_TRAPEZOID_REL);
  wire is_wclr    = (i_cmd_type == `RPSS_CMD_WORK_RECT_CLEAR);
  wire cmd_src    = is_mv | is_bin | is_pattern_line_abs;
  wire cmd_param  = is_pc | is_sline | is_wline;
  wire cmd_wwrite = is_wtrap | is_wline | is_wclr;
  wire cmd_draws  = cmd_src | cmd_param;

  // masked read only for quad fills with the work attribute
  wire cmd_wread  = (is_mv | is_bin | is_pc) &
                    i_cmd_mode[`RPSS_ATTR_POS0];
  // transparency only meaningful for source fills and pattern lines
  wire cmd_transparency_sel   = (is_mv | is_bin | is_pattern_line_abs) &
                    i_cmd_mode[`RPSS_ATTR_TRANSPARENCY_SEL];

  //////////////////////////////////////////////////////////////////////////////
  // fifo between expansion and pixel sink
  wire        ff_wr_ready;
  wire        ff_wr_valid;
  wire [16:0] ff_wr_data;
  wire        ff_rd_valid;
  wire [16:0] ff_rd_data;
  wire        ff_rd_ready = ~o_pix_valid | i_pix_ready;

  rpss_fifo
  #(
    .WIDTH (17),
    .DEPTH (`RPSS_FIFO_DEPTH),
    .AW    (`RPSS_FIFO_AW)
  )
  u_fifo
  (
    .i_sys_clk  (i_sys_clk),
    .i_sys_rst  (i_sys_rst),
    .i_wr_valid (ff_wr_valid),
    .i_wr_data  (ff_wr_data),
    .o_wr_ready (ff_wr_ready),
    .o_rd_valid (ff_rd_valid),
    .o_rd_data  (ff_rd_data),
    .i_rd_ready (ff_rd_ready)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pixel expansion of the current word
  wire        cur_is_mv  = (cmd_q == `RPSS_CMD_QUAD_FILL_MULTIVALUE_SRC);
  wire        cur_is_pc  = (cmd_q == `RPSS_CMD_QUAD_FILL_PARAM_COLOR) |
                           (cmd_q == `RPSS_CMD_SOLID_LINE_ABS) |
                           (cmd_q == `RPSS_CMD_SOLID_LINE_REL) |
                           (cmd_q == `RPSS_CMD_WORK_LINE_ABS) |
                           (cmd_q == `RPSS_CMD_WORK_LINE_REL);
  wire        cur_wread  = o_read_work;
  wire [3:0]  last_idx   = cur_is_pc ? 4'h0 :
                           cur_is_mv ? (pix16_q ? 4'h0 : 4'h1) : 4'hf;
  wire        bin_bit    = word_q[bit_idx_q];
  wire [7:0]  mv_byte    = bit_idx_q[0] ? word_q[15:8] : word_q[7:0];
  reg  [15:0] exp_color;
  reg         exp_write;

  // colour and write decision for one pixel
  always @*
  begin
    exp_color = `RPSS_ZERO_PIX;
    exp_write = 1'b0;
    if (cur_is_pc)
    begin
      exp_color = fg_q;
      exp_write = 1'b1;
    end
    else if (cur_is_mv)
    begin
      exp_color = pix16_q ? word_q : {8'h00, mv_byte};
      exp_write = pix16_q ? (word_q != `RPSS_ZERO_PIX)
                          : (mv_byte != 8'h00);
    end
    else
    begin
      exp_color = bin_bit ? fg_q : bg_q;
      exp_write = bin_bit | ~o_transparency_sel;
    end
    // mask from the same pass gates the draw
    if (cur_wread & ~word_work_q)
      exp_write = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencing
  wire take_word = (state_q == ST_RUN) & (~have_word_q) & i_src_valid;
  wire emit      = (state_q == ST_RUN) & have_word_q & ff_wr_ready;
  wire word_done = emit & (bit_idx_q == last_idx);

  // push in the cycle that saw room, so a full fifo never drops a pixel
  assign ff_wr_valid = emit;
  assign ff_wr_data  = {exp_write, exp_color};

  // next state
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (i_cmd_valid & cmd_draws)
          state_d = ST_RUN;
      ST_RUN:
        if (word_done & word_last_q)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // command latch, attribute decode and datapath
  always @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      state_q                <= ST_IDLE;
      cmd_q                  <= `RPSS_CMD_OTHER;
      attr_q                 <= 10'h000;
      bg_q                   <= `RPSS_ZERO_PIX;
      fg_q                   <= `RPSS_ZERO_PIX;
      pix16_q                <= 1'b0;
      word_q                 <= `RPSS_ZERO_PIX;
      word_work_q            <= 1'b0;
      word_last_q            <= 1'b0;
      bit_idx_q              <= 4'h0;
      have_word_q            <= 1'b0;
      o_src_ready            <= 1'b0;
      o_src_class            <= `RPSS_SRC_NONE;
      o_fetch_source         <= 1'b0;
      o_read_work            <= 1'b0;
      o_write_work           <= 1'b0;
      o_work_value           <= 1'b0;
      o_busy                 <= 1'b0;
      o_transparency_sel     <= 1'b0;
      o_source_repeat_style  <= 1'b0;
      o_user_enable_a        <= 1'b0;
      o_relative_source_addr <= 1'b0;
      o_net_draw             <= 1'b0;
      o_even_odd_select      <= 1'b0;
      o_cmd_dep_bits         <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      // a new command is decoded only when idle
      if ((state_q == ST_IDLE) & i_cmd_valid)
      begin
        cmd_q                  <= i_cmd_type;
        attr_q                 <= i_cmd_mode[9:0];
        bg_q                   <= i_background_color;
        fg_q                   <= i_foreground_color;
        pix16_q                <= i_pix16_mode;
        o_src_class            <= cmd_src ? `RPSS_SRC_IMAGE :
                                  cmd_param ? `RPSS_SRC_PARAM : `RPSS_SRC_NONE;
        o_fetch_source         <= cmd_src;
        o_read_work            <= cmd_wread;
        o_write_work           <= cmd_wwrite;
        o_work_value           <= is_wline &
                                  i_cmd_mode[`RPSS_ATTR_EVEN_ODD_SELECT];
        o_transparency_sel     <= cmd_transparency_sel;
        o_source_repeat_style  <= i_cmd_mode[`RPSS_ATTR_SOURCE_REPEAT];
        o_user_enable_a        <= i_cmd_mode[`RPSS_ATTR_USER_ENABLE_A];
        o_relative_source_addr <= i_cmd_mode[`RPSS_ATTR_RELATIVE_ADDR];
        o_net_draw             <= i_cmd_mode[`RPSS_ATTR_NET];
        o_even_odd_select      <= i_cmd_mode[`RPSS_ATTR_EVEN_ODD_SELECT];
        o_cmd_dep_bits         <= i_cmd_mode[`RPSS_ATTR_POS3:`RPSS_ATTR_POS0];
      end
      o_busy      <= (state_d == ST_RUN);
      o_src_ready <= (state_d == ST_RUN) & ~(have_word_q | take_word) ? 1'b1 :
                     (state_d == ST_RUN) & word_done & ~word_last_q;
      // word capture and pixel stepping
      if (take_word & o_src_ready)
      begin
        word_q      <= i_src_word;
        word_work_q <= i_src_work_bit;
        word_last_q <= i_src_last;
        bit_idx_q   <= 4'h0;
        have_word_q <= 1'b1;
      end
      else if (emit)
      begin
        bit_idx_q <= bit_idx_q + 4'h1;
        if (bit_idx_q == last_idx)
          have_word_q <= 1'b0;
      end
    end
  end

  // fifo read side drives the registered pixel outputs
  always @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      o_pix_valid <= 1'b0;
      o_pix_color <= `RPSS_ZERO_PIX;
      o_pix_write <= 1'b0;
    end
    else if (ff_rd_ready)
    begin
      o_pix_valid <= ff_rd_valid;
      o_pix_color <= ff_rd_data[15:0];
      o_pix_write <= ff_rd_data[16] & ff_rd_valid;
    end
  end

endmodule
`default_nettype wire

/* test/rpss_properties.sv */
// Purpose: port assertions for the pixel source select block
// Assumes: one clock, synchronous active-high reset
// Notes:   the command type is latched whenever a command is taken
`timescale 1ns/100ps
`default_nettype none
`include "rpss_defines.vh"
module rpss_properties
(
  // clock and reset
  input  wire        i_sys_clk,
  input  wire        i_sys_rst,
  // command and sink side
  input  wire        i_cmd_valid,
  input  wire [3:0]  i_cmd_type,
  input  wire [15:0] i_cmd_mode,
  input  wire        i_pix_ready,
  // watched outputs
  input  wire        o_busy,
  input  wire        o_src_ready,
  input  wire [1:0]  o_src_class,
  input  wire        o_fetch_source,
  input  wire        o_read_work,
  input  wire        o_write_work,
  input  wire        o_work_value,
  input  wire        o_transparency_sel,
  input  wire        o_source_repeat_style,
  input  wire        o_user_enable_a,
  input  wire        o_relative_source_addr,
  input  wire        o_net_draw,
  input  wire        o_even_odd_select,
  input  wire [3:0]  o_cmd_dep_bits,
  input  wire        o_pix_valid,
  input  wire [15:0] o_pix_color,
  input  wire        o_pix_write
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  wire       take = i_cmd_valid && !o_busy;
  reg  [3:0] typ_q;

  // source class expected for a command code
  function automatic [1:0] cls(input [3:0] t);
    case (t)
      4'h0, 4'h1, 4'h5, 4'h6:       cls = `RPSS_SRC_IMAGE;
      4'h2, 4'h3, 4'h4, 4'h7, 4'h8: cls = `RPSS_SRC_PARAM;
      default:                      cls = `RPSS_SRC_NONE;
    endcase
  endfunction

  // remember the type of the command in force
  always @(posedge i_sys_clk)
    if (i_sys_rst)
      typ_q <= 4'hf;
    else if (take)
      typ_q <= i_cmd_type;

  ////////////////////////////////////////////////////////////////////////////
  a_fetch_image:
    assert property (take |=> o_fetch_source == (cls(typ_q) == `RPSS_SRC_IMAGE))
    else $error("source fetch decode wrong");
  a_class_decode:
    assert property (take |=> o_src_class == cls(typ_q))
    else $error("source class decode wrong");
  a_mask_read:
    assert property (take |=> o_read_work == (typ_q <= 4'h2 && $past(i_cmd_mode[0])))
    else $error("work mask read decode wrong");
  a_work_write:
    assert property (take |=> o_write_work == (typ_q >= 4'h7 && typ_q <= 4'hb))
    else $error("work write decode wrong");
  a_work_value:
    assert property (take && (i_cmd_type == 4'h7 || i_cmd_type == 4'h8)
                     |=> o_work_value == $past(i_cmd_mode[4]))
    else $error("work value not from even/odd select");
  a_trans_sel:
    assert property (take |=> o_transparency_sel ==
                     ($past(i_cmd_mode[9]) && cls(typ_q) == `RPSS_SRC_IMAGE))
    else $error("transparency decode wrong");
  a_attr_bits:
    assert property (take && i_cmd_type == 4'h0 |=> {o_source_repeat_style, o_user_enable_a,
                     o_relative_source_addr, o_net_draw, o_even_odd_select,
                     o_cmd_dep_bits} == $past(i_cmd_mode[8:0]))
    else $error("attribute bits decode wrong");
  a_cmd_refused:
    assert property (i_cmd_valid && o_busy |=> $stable(o_src_class) && $stable(o_read_work))
    else $error("command taken while busy");
  a_zero_skip:
    assert property (o_pix_valid && o_pix_write && typ_q == 4'h0 |-> o_pix_color != 16'h0000)
    else $error("all-zero source pixel drawn");
  a_pix_hold:
    assert property (o_pix_valid && !i_pix_ready |=> o_pix_valid && $stable(o_pix_color)
                     && $stable(o_pix_write))
    else $error("pixel changed while stalled");
  a_ready_busy:
    assert property (o_src_ready |-> o_busy)
    else $error("source ready while idle");
  a_reset_idle:
    assert property ($fell(i_sys_rst) |-> !o_busy && !o_pix_valid && o_src_class == 2'h0)
    else $error("outputs not idle after reset");
endmodule
`default_nettype wire

/* test/rpss_fetch_model.sv */
// Purpose: command fetcher model offering source words
// Assumes: words move on valid and ready at a rising edge
// Notes:   released lines carry the inverse of the last word
`timescale 1ns/100ps
`default_nettype none
module rpss_fetch_model
(
  // clock
  input  wire         i_sys_clk,
  // source stream toward the block
  output logic        o_src_valid,
  output logic [15:0] o_src_word,
  output logic        o_src_work_bit,
  output logic        o_src_last,
  input  wire         i_src_ready
);
  int miss_count = 0;
  int gap = 0;
  initial
  begin
    o_src_valid = 1'b0;
    o_src_word = 16'h0000;
    o_src_work_bit = 1'b0;
    o_src_last = 1'b0;
  end

  // offer one whole word and hold it until taken, releasing it and counting a miss after 400 cycles
  task automatic send(input logic [15:0] w, input logic m, input logic l);
    int n;
    repeat (gap) @(posedge i_sys_clk);
    #1;
    o_src_valid = 1'b1;
    o_src_word = w;
    o_src_work_bit = m;
    o_src_last = l;
    n = 0;
    @(posedge i_sys_clk);
    while (!i_src_ready && n < 400)
    begin
      n++;
      @(posedge i_sys_clk);
    end
    if (n == 400)
      miss_count++;
    #1;
    o_src_valid = 1'b0;
    o_src_word = ~w;
    o_src_work_bit = ~m;
    o_src_last = ~l;
  endtask
endmodule
`default_nettype wire

/* test/rpss_top_bench.sv */
// Purpose: self-checking bench for the pixel source select block
// Assumes: 25 MHz clock, inputs move 1 ns after the rising edge
// Notes:   decode cases in a table, pixel streams checked by hand
`timescale 1ns/100ps
`default_nettype none
module rpss_top_bench;
  typedef struct {logic [3:0] t; logic [15:0] m; logic [1:0] c; logic [3:0] f;} rpss_row_t;
  logic        clk = 0, rst = 1, cmd_valid = 0, pix16 = 0, pix_ready = 0, hold = 0;
  logic [3:0]  cmd_type = 4'hf;
  logic [15:0] cmd_mode = 16'h0000, bg = 16'h3434, fg = 16'h5656;
  wire         s_valid, s_work, s_last, s_ready, busy, fetch, rdw, wrw, wval, trans;
  wire         pix_valid, pix_write;
  wire  [1:0]  s_class;
  wire  [15:0] s_word, pix_color;
  int          num_errors = 0, check_count = 0;
  logic [17:0] got[$], exp[$];
  // type, mode, class, {fetch, mask read, work write, transparency}
  rpss_row_t rows[13] = '{'{4'h0, 16'h03b5, 2'h1, 4'hd}, '{4'h1, 16'h0000, 2'h1, 4'h8},
    '{4'h2, 16'h0001, 2'h2, 4'h4}, '{4'h3, 16'h0000, 2'h2, 4'h0}, '{4'h4, 16'h0010, 2'h2, 4'h0},
    '{4'h5, 16'h0301, 2'h1, 4'h9}, '{4'h6, 16'h0101, 2'h1, 4'h8}, '{4'h7, 16'h0010, 2'h2, 4'h2},
    '{4'h8, 16'h0000, 2'h2, 4'h2}, '{4'h9, 16'h0000, 2'h0, 4'h2}, '{4'ha, 16'h0000, 2'h0, 4'h2},
    '{4'hb, 16'h0000, 2'h0, 4'h2}, '{4'hf, 16'h0000, 2'h0, 4'h0}};

  rpss_fetch_model u_src (.i_sys_clk(clk), .o_src_valid(s_valid), .o_src_word(s_word),
    .o_src_work_bit(s_work), .o_src_last(s_last), .i_src_ready(s_ready));
  rpss_top i_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_cmd_valid(cmd_valid),
    .i_cmd_type(cmd_type), .i_cmd_mode(cmd_mode), .i_background_color(bg),
    .i_foreground_color(fg), .i_pix16_mode(pix16), .i_src_valid(s_valid), .i_src_word(s_word),
    .i_src_work_bit(s_work), .i_src_last(s_last), .o_src_ready(s_ready), .o_src_class(s_class),
    .o_fetch_source(fetch), .o_read_work(rdw), .o_write_work(wrw), .o_work_value(wval),
    .o_busy(busy), .o_transparency_sel(trans), .o_source_repeat_style(), .o_user_enable_a(),
    .o_relative_source_addr(), .o_net_draw(), .o_even_odd_select(), .o_cmd_dep_bits(),
    .o_pix_valid(pix_valid), .o_pix_color(pix_color), .o_pix_write(pix_write),
    .i_pix_ready(pix_ready));

  // clock, stalling sink and pixel capture
  initial forever #20 clk = ~clk;
  always @(posedge clk)
  begin
    if (pix_valid && pix_ready)
      got.push_back({1'b0, pix_write, pix_color});
    #1 pix_ready = !hold && !pix_ready;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one command pulse; returns when decode is settled
  task automatic issue(input logic [3:0] t, input logic [15:0] m);
    @(posedge clk) #1;
    cmd_valid = 1'b1;
    cmd_type = t;
    cmd_mode = m;
    @(posedge clk) #1;
    cmd_valid = 1'b0;
  endtask
  // idle only once busy and pixel valid have both stayed low a few cycles
  task automatic wait_idle;
    int n;
    int quiet;
    n = 0;
    quiet = 0;
    while (quiet < 6 && n < 400)
    begin
      @(posedge clk) #1;
      n++;
      quiet = (busy === 1'b0 && pix_valid === 1'b0) ? quiet + 1 : 0;
    end
    check(n == 400, 0);
  endtask
  // expected pixels of one binary word, lsb first
  function automatic void bin_word(input logic [15:0] w, input logic tr);
    for (int i = 0; i < 16; i++)
      exp.push_back({w[i] | !tr, w[i] | !tr, w[i] ? fg : bg});
  endfunction
  task automatic cmp_pix;
    check(got.size(), exp.size());
    foreach (exp[i])
      if (i < got.size())
      begin
        check(got[i][16], exp[i][16]);
        if (exp[i][17])
          check(got[i][15:0], exp[i][15:0]);
      end
    got.delete();
    exp.delete();
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst = 0;
    @(posedge clk) #1;
    check({busy, pix_valid, s_class}, 0);
    // decode table; some rows set mode bits that their command does not use
    foreach (rows[k])
    begin
      issue(rows[k].t, rows[k].m);
      check(s_class, rows[k].c);
      check({fetch, rdw, wrw, trans}, rows[k].f);
      if (rows[k].t inside {4'h7, 4'h8})
        check(wval, rows[k].m[4]);
      if (busy)
        u_src.send(16'h0000, 1'b0, 1'b1);
      wait_idle();
      got.delete();
    end
    // binary opaque then transparent, the second with a 3-cycle source gap
    issue(4'h1, 16'h0000);
    u_src.send(16'h80a5, 1'b0, 1'b1);
    wait_idle();
    bin_word(16'h80a5, 1'b0);
    cmp_pix();
    u_src.gap = 3;
    issue(4'h1, 16'h0200);
    u_src.send(16'h0f01, 1'b0, 1'b1);
    wait_idle();
    bin_word(16'h0f01, 1'b1);
    cmp_pix();
    // multivalue at 16 bpp and at 8 bpp
    pix16 = 1'b1;
    issue(4'h0, 16'h0000);
    u_src.send(16'hbeef, 1'b0, 1'b0);
    u_src.send(16'h0000, 1'b0, 1'b1);
    wait_idle();
    exp = '{18'h3beef, 18'h00000};
    cmp_pix();
    pix16 = 1'b0;
    issue(4'h0, 16'h0000);
    u_src.send(16'h5a00, 1'b0, 1'b1);
    wait_idle();
    exp = '{18'h00000, 18'h3005a};
    cmp_pix();
    // parameter colour through the work mask
    pix16 = 1'b1;
    fg = 16'h7c1f;
    u_src.gap = 0;
    issue(4'h2, 16'h0001);
    u_src.send(16'h1234, 1'b1, 1'b0);
    u_src.send(16'h1234, 1'b0, 1'b1);
    wait_idle();
    exp = '{18'h37c1f, 18'h00000};
    cmp_pix();
    // second command while running is ignored
    issue(4'h1, 16'h0000);
    issue(4'h2, 16'h0001);
    check({s_class, rdw}, 3'h2);
    // fifo fills with the sink stalled, then drains
    hold = 1'b1;
    fork
      begin
        u_src.send(16'hffff, 1'b0, 1'b0);
        u_src.send(16'h00ff, 1'b0, 1'b0);
        u_src.send(16'h1234, 1'b0, 1'b0);
        u_src.send(16'hc3c3, 1'b0, 1'b1);
      end
    join_none
    repeat (150) @(posedge clk);
    #2 check({s_ready, pix_valid}, 2'h1);
    hold = 1'b0;
    wait_idle();
    bin_word(16'hffff, 1'b0);
    bin_word(16'h00ff, 1'b0);
    bin_word(16'h1234, 1'b0);
    bin_word(16'hc3c3, 1'b0);
    cmp_pix();
    // reset in mid-run
    issue(4'h1, 16'h0000);
    u_src.send(16'h5555, 1'b0, 1'b0);
    rst = 1'b1;
    repeat (2) @(posedge clk) #1;
    rst = 1'b0;
    @(posedge clk) #1;
    check({busy, pix_valid, s_class}, 0);
    got.delete();
    // first command after reset draws the parameter colour
    issue(4'h3, 16'h0000);
    u_src.send(16'h0000, 1'b0, 1'b1);
    wait_idle();
    exp = '{18'h37c1f};
    cmp_pix();
    check(u_src.miss_count, 0);
    close_out();
  end
endmodule

bind rpss_top rpss_properties u_props (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
  .i_cmd_valid(i_cmd_valid), .i_cmd_type(i_cmd_type), .i_cmd_mode(i_cmd_mode),
  .i_pix_ready(i_pix_ready), .o_busy(o_busy), .o_src_ready(o_src_ready),
  .o_src_class(o_src_class), .o_fetch_source(o_fetch_source), .o_read_work(o_read_work),
  .o_write_work(o_write_work), .o_work_value(o_work_value),
  .o_transparency_sel(o_transparency_sel), .o_source_repeat_style(o_source_repeat_style),
  .o_user_enable_a(o_user_enable_a), .o_relative_source_addr(o_relative_source_addr),
  .o_net_draw(o_net_draw), .o_even_odd_select(o_even_odd_select),
  .o_cmd_dep_bits(o_cmd_dep_bits), .o_pix_valid(o_pix_valid), .o_pix_color(o_pix_color),
  .o_pix_write(o_pix_write));
`default_nettype wire
